// ===== logic/smc_cmd_unit.sv
// Purpose: command interpreter of a secure single-wire memory token
// Assumes: link bit timing and ROM stage handled outside; memory read is combinational
// Notes:   SHA core is outside; this unit sequences it and owns the flags
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.svh"
// Operation
// - memory read covers pages 0-15, counter pages 19-20, prng counter
// - secret pages read as FFh; scratchpad page reads FFh while concealed
// - twelve bytes after prng counter undefined, further reads give ones
// - after memory read target address holds last byte read, status untouched
// - erase takes address only, fills scratchpad with FFh, clears conceal flag
// - erase returns ones for about 32 us, then alternating bits
// - match compares master bytes against scratchpad bytes 8 to 27
// - full match gives alternating bits, sets verified if host flag set
// - authenticated read sends page tail, both counters, inverted crc
// - after that crc a mac is computed into scratchpad bytes 8 to 27
// - ones while the hash runs, alternating bits once it finishes
// - compute takes address and control byte, sends crc, then starts hashing
// - invalid control byte or address gives ones until reset pulse, no hash
// - sign only pages 0 and 8; challenge and host host_flag_a never there
// - challenge latches upper three low-address bits as secret number
// - host host_flag_a sets host flag only when latched secret matches page secret
// - control bit m needs verified flag and same secret pair
// - power-on reset sets the conceal flag
// - low nibble of message control byte is the page number for authenticated read and challenge only
module smc_cmd_unit (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   rstn,
   // link side
   input  wire smc_pkg::smc_link_req_t link_req,
   output smc_pkg::smc_link_rsp_t      link_rsp,
   // memory read port
   output logic [9:0]                  mem_raddr,
   input  wire logic [7:0]             mem_rdata,
   // hash engine
   output smc_pkg::smc_sha_req_t       sha_req,
   input  wire logic                   sha_done,
   input  wire logic [159:0]           sha_mac,
   // register port
   input  wire logic [1:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic [7:0]                  reg_rdata
);
   localparam logic [11:0] ERASE_CYC = 12'(`SMC_ERASE_CYC);

   smc_pkg::smc_state_t st_q, st_d;
   smc_pkg::smc_func_t  fn_q, fn_d;
   logic [7:0]          cmd_q, cmd_d;
   logic [15:0]         ta_q, ta_d;
   logic [15:0]         rp_q, rp_d;
   logic [15:0]         crc_q, crc_d;
   logic [4:0]          cnt_q, cnt_d;
   logic [11:0]         tmr_q, tmr_d;
   logic                ok_q, ok_d;
   logic                alt_q, alt_d;
   logic                scratchpad_conceal_flag_q, scratchpad_conceal_flag_d;
   logic                host_flag_a_q, host_flag_a_d;
   logic                match_q, match_d;
   logic [2:0]          sec_q, sec_d;
   logic [7:0]          ctrl_q, ctrl_d;
   logic [7:0]          sp_q [32];
   logic [7:0]          sp_d [32];
   smc_pkg::smc_link_rsp_t rsp_d;
   smc_pkg::smc_sha_req_t  sha_d;
   logic [7:0]          rdat_d;
   logic [7:0]          view;
   logic [7:0]          tx;
   logic [3:0]          page;
   logic                mbit;

   function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ b[i]) begin
            r = (r >> 1) ^ 16'hA001;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   assign page = ta_q[8:5];
   assign mbit = match_q && (sec_q[2:1] == page[2:1]);

   // byte seen by a plain memory read at rp_q
   always_comb begin
      view = mem_rdata;
      if (rp_q[15:10] != 6'h00 || rp_q[9:5] > `SMC_PG_PRNG) begin
         view = 8'hFF;
      end else if (rp_q[9:5] == `SMC_PG_SECRET_A || rp_q[9:5] == `SMC_PG_SECRET_B) begin
         view = 8'hFF;
      end else if (rp_q[9:5] == `SMC_PG_SCRATCH) begin
         view = scratchpad_conceal_flag_q ? 8'hFF : sp_q[rp_q[4:0]];
      end else if (rp_q[9:5] == `SMC_PG_PRNG && rp_q[4:0] >= `SMC_PRNG_BYTES) begin
         view = 8'hFF;
      end
   end

   // memory address: page bytes, then page counter, then secret counter
   always_comb begin
      mem_raddr = rp_q[9:0];
      if (st_q == smc_pkg::ST_HOST_FLAG_A_RD && cnt_q != 5'h00) begin
         if (cnt_q <= 5'h04) begin
            mem_raddr = `SMC_PAGE_CTR_BASE + {4'h0, page, 2'b00} + 10'(cnt_q - 5'h01);
         end else begin
            mem_raddr = `SMC_SEC_CTR_BASE + {5'h00, page[2:0], 2'b00} + 10'(cnt_q - 5'h05);
         end
      end
   end

   always_comb begin
      st_d    = st_q;
      fn_d    = fn_q;
      cmd_d   = cmd_q;
      ta_d    = ta_q;
      rp_d    = rp_q;
      crc_d   = crc_q;
      cnt_d   = cnt_q;
      tmr_d   = tmr_q;
      ok_d    = ok_q;
      alt_d   = alt_q;
      scratchpad_conceal_flag_d  = scratchpad_conceal_flag_q;
      host_flag_a_d  = host_flag_a_q;
      match_d = match_q;
      sec_d   = sec_q;
      sp_d    = sp_q;
      tx      = 8'hFF;
      rsp_d   = '{valid: link_req.rd_byte | link_req.rd_bit, data: 8'hFF};
      sha_d   = '{start: 1'b0, func: fn_q, page: page, msg_ctrl: 8'h00};
      if (fn_q == smc_pkg::FN_READ_HOST_FLAG_A || fn_q == smc_pkg::FN_CHALL) begin
         sha_d.msg_ctrl = {mbit, ctrl_q[0], 2'b00, page};
      end else begin
         sha_d.msg_ctrl = {mbit, ctrl_q[0], sp_q[`SMC_MPX_BYTE][5:0]};
      end
      if (link_req.reset_pulse) begin
         st_d = smc_pkg::ST_IDLE;
      end else begin
         unique case (st_q)
            smc_pkg::ST_IDLE: begin
               if (link_req.wr_valid) begin
                  cmd_d = link_req.wr_byte;
                  crc_d = crc16(16'h0000, link_req.wr_byte);
                  fn_d  = smc_pkg::FN_NONE;
                  cnt_d = `SMC_MAC_FIRST;
                  ok_d  = 1'b0;
                  if (link_req.wr_byte == `SMC_CMD_MATCH_SP) begin
                     st_d = smc_pkg::ST_MATCH;
                  end else if (link_req.wr_byte == `SMC_CMD_READ_MEM ||
                               link_req.wr_byte == `SMC_CMD_ERASE_SP ||
                               link_req.wr_byte == `SMC_CMD_READ_HOST_FLAG_A ||
                               link_req.wr_byte == `SMC_CMD_COMPUTE) begin
                     st_d = smc_pkg::ST_ADDR_LO;
                  end else begin
                     st_d = smc_pkg::ST_ONES;
                  end
               end
            end
            smc_pkg::ST_ADDR_LO: begin
               if (link_req.wr_valid) begin
                  rp_d[7:0] = link_req.wr_byte;
                  crc_d     = crc16(crc_q, link_req.wr_byte);
                  st_d      = smc_pkg::ST_ADDR_HI;
               end
            end
            smc_pkg::ST_ADDR_HI: begin
               if (link_req.wr_valid) begin
                  rp_d[15:8] = link_req.wr_byte;
                  ta_d       = {link_req.wr_byte, rp_q[7:0]};
                  crc_d      = crc16(crc_q, link_req.wr_byte);
                  cnt_d      = 5'h00;
                  if (cmd_q == `SMC_CMD_READ_MEM) begin
                     st_d = smc_pkg::ST_READ;
                  end else if (cmd_q == `SMC_CMD_ERASE_SP) begin
                     for (int i = 0; i < 32; i++) begin
                        sp_d[i] = 8'hFF;
                     end
                     scratchpad_conceal_flag_d = 1'b0;
                     tmr_d  = ERASE_CYC;
                     st_d   = smc_pkg::ST_ERASE;
                  end else if (cmd_q == `SMC_CMD_READ_HOST_FLAG_A) begin
                     fn_d = smc_pkg::FN_READ_HOST_FLAG_A;
                     st_d = ({link_req.wr_byte, rp_q[7:0]} < `SMC_DATA_LIMIT) ?
                            smc_pkg::ST_HOST_FLAG_A_RD : smc_pkg::ST_ONES;
                  end else begin
                     st_d = smc_pkg::ST_CTRL;
                  end
               end
            end
            smc_pkg::ST_READ: begin
               if (link_req.rd_byte) begin
                  tx   = view;
                  ta_d = rp_q;
                  rp_d = rp_q + 16'h0001;
               end
            end
            smc_pkg::ST_HOST_FLAG_A_RD: begin
               if (link_req.rd_byte) begin
                  tx    = mem_rdata;
                  crc_d = crc16(crc_q, mem_rdata);
                  if (cnt_q == 5'h00) begin
                     rp_d = rp_q + 16'h0001;
                     if (rp_q[4:0] == 5'h1F) begin
                        cnt_d = 5'h01;
                     end
                  end else if (cnt_q == 5'h08) begin
                     cnt_d = 5'h00;
                     st_d  = smc_pkg::ST_CRC;
                  end else begin
                     cnt_d = cnt_q + 5'h01;
                  end
               end
            end
            smc_pkg::ST_MATCH: begin
               if (link_req.wr_valid) begin
                  crc_d = crc16(crc_q, link_req.wr_byte);
                  if (link_req.wr_byte != sp_q[cnt_q]) begin
                     ok_d = 1'b1; // mismatch seen
                  end
                  if (cnt_q == `SMC_MAC_LAST) begin
                     cnt_d = 5'h00;
                     st_d  = smc_pkg::ST_CRC;
                  end else begin
                     cnt_d = cnt_q + 5'h01;
                  end
               end
            end
            smc_pkg::ST_CTRL: begin
               if (link_req.wr_valid) begin
                  crc_d = crc16(crc_q, link_req.wr_byte);
                  cnt_d = 5'h00;
                  st_d  = smc_pkg::ST_CRC;
                  unique case (link_req.wr_byte)
                     `SMC_FN_CODE_VALIDATE: fn_d = smc_pkg::FN_VALIDATE;
                     `SMC_FN_CODE_SIGN:     fn_d = smc_pkg::FN_SIGN;
                     `SMC_FN_CODE_CHALL:    fn_d = smc_pkg::FN_CHALL;
                     `SMC_FN_CODE_AUTHHOST: fn_d = smc_pkg::FN_AUTHHOST;
                     `SMC_FN_CODE_FIRST:    fn_d = smc_pkg::FN_FIRST;
                     `SMC_FN_CODE_NEXT:     fn_d = smc_pkg::FN_NEXT;
                     default:               fn_d = smc_pkg::FN_NONE;
                  endcase
                  ok_d = (fn_d != smc_pkg::FN_NONE) && (ta_q < `SMC_DATA_LIMIT);
                  if (fn_d == smc_pkg::FN_SIGN && page[2:0] != 3'h0) begin
                     ok_d = 1'b0;
                  end
                  if ((fn_d == smc_pkg::FN_CHALL || fn_d == smc_pkg::FN_AUTHHOST) &&
                      page[2:0] == 3'h0) begin
                     ok_d = 1'b0;
                  end
               end
            end
            smc_pkg::ST_CRC: begin
               if (link_req.rd_byte) begin
                  tx    = (cnt_q == 5'h00) ? ~crc_q[7:0] : ~crc_q[15:8];
                  cnt_d = 5'h01;
                  alt_d = 1'b0;
                  if (cnt_q != 5'h00) begin
                     if (cmd_q == `SMC_CMD_MATCH_SP) begin
                        st_d = ok_q ? smc_pkg::ST_ONES : smc_pkg::ST_ALT;
                        if (!ok_q && host_flag_a_q) begin
                           match_d = 1'b1;
                        end
                     end else if (cmd_q == `SMC_CMD_COMPUTE && !ok_q) begin
                        st_d = smc_pkg::ST_ONES;
                     end else begin
                        sha_d.start = 1'b1;
                        st_d        = smc_pkg::ST_SHA;
                        if (fn_q == smc_pkg::FN_CHALL) begin
                           sec_d = ta_q[7:5];
                        end
                     end
                  end
               end
            end
            smc_pkg::ST_ERASE: begin
               if (tmr_q <= 12'h001) begin
                  st_d = smc_pkg::ST_ALT;
               end else begin
                  tmr_d = tmr_q - 12'h001;
               end
            end
            smc_pkg::ST_SHA: begin
               if (sha_done) begin
                  for (int i = 0; i < 20; i++) begin
                     sp_d[`SMC_MAC_FIRST + i] = sha_mac[159 - 8 * i -: 8];
                  end
                  if (fn_q == smc_pkg::FN_AUTHHOST && sec_q == page[2:0]) begin
                     host_flag_a_d = 1'b1;
                  end
                  if (fn_q == smc_pkg::FN_VALIDATE || fn_q == smc_pkg::FN_AUTHHOST) begin
                     scratchpad_conceal_flag_d = 1'b1;
                  end
                  st_d = smc_pkg::ST_ALT;
               end
            end
            smc_pkg::ST_ALT: begin
               if (link_req.rd_bit) begin
                  tx    = {7'h00, alt_q};
                  alt_d = ~alt_q;
               end
            end
            smc_pkg::ST_ONES: begin
            end
         endcase
      end
      if (link_req.rd_bit && st_q != smc_pkg::ST_ALT) begin
         tx = 8'h01;
      end
      rsp_d.data = tx;
   end

   // register port: status read-only, control bit 0 feeds control bit x
   always_comb begin
      ctrl_d = ctrl_q;
      rdat_d = 8'h00;
      if (reg_wr && reg_addr == `SMC_REG_CTRL) begin
         ctrl_d = {7'h00, reg_wdata[0]};
      end
      if (reg_rd && reg_addr == `SMC_REG_STATUS) begin
         rdat_d = {2'b00, scratchpad_conceal_flag_q, host_flag_a_q, match_q, sec_q};
      end else if (reg_rd && reg_addr == `SMC_REG_CTRL) begin
         rdat_d = ctrl_q;
      end
   end

   // async reset doubles as power-on reset, so the conceal flag comes up set
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_q      <= smc_pkg::ST_IDLE;
         fn_q      <= smc_pkg::FN_NONE;
         cmd_q     <= 8'h00;
         ta_q      <= 16'h0000;
         rp_q      <= 16'h0000;
         crc_q     <= 16'h0000;
         cnt_q     <= 5'h00;
         tmr_q     <= 12'h000;
         ok_q      <= 1'b0;
         alt_q     <= 1'b0;
         scratchpad_conceal_flag_q    <= 1'b1;
         host_flag_a_q    <= 1'b0;
         match_q   <= 1'b0;
         sec_q     <= 3'h0;
         ctrl_q    <= `SMC_CTRL_RST;
         link_rsp  <= '0;
         sha_req   <= '0;
         reg_rdata <= 8'h00;
         for (int i = 0; i < 32; i++) begin
            sp_q[i] <= 8'h00;
         end
      end else begin
         st_q      <= st_d;
         fn_q      <= fn_d;
         cmd_q     <= cmd_d;
         ta_q      <= ta_d;
         rp_q      <= rp_d;
         crc_q     <= crc_d;
         cnt_q     <= cnt_d;
         tmr_q     <= tmr_d;
         ok_q      <= ok_d;
         alt_q     <= alt_d;
         scratchpad_conceal_flag_q    <= scratchpad_conceal_flag_d;
         host_flag_a_q    <= host_flag_a_d;
         match_q   <= match_d;
         sec_q     <= sec_d;
         ctrl_q    <= ctrl_d;
         link_rsp  <= rsp_d;
         sha_req   <= sha_d;
         reg_rdata <= rdat_d;
         sp_q      <= sp_d;
      end
   end

   erase_clears_a: assert property (@(posedge clk) disable iff (!rstn)
      st_q == smc_pkg::ST_ERASE |-> !scratchpad_conceal_flag_q && sp_q[0] == 8'hFF && sp_q[31] == 8'hFF)
      else $error("erase left conceal flag or data");
   // a reset pulse may cut the erase short, so only an unbroken count must hold the state
   erase_busy_a: assert property (@(posedge clk) disable iff (!rstn)
      st_q == smc_pkg::ST_ERASE && tmr_q > 12'h001 && !link_req.reset_pulse
      |=> st_q == smc_pkg::ST_ERASE)
      else $error("erase ended too early");
   secret_hidden_a: assert property (@(posedge clk) disable iff (!rstn)
      st_q == smc_pkg::ST_READ && link_req.rd_byte && !link_req.reset_pulse &&
      (rp_q[9:5] == `SMC_PG_SECRET_A || rp_q[9:5] == `SMC_PG_SECRET_B)
      |=> link_rsp.data == 8'hFF)
      else $error("secret page leaked");
   read_addr_a: assert property (@(posedge clk) disable iff (!rstn)
      st_q == smc_pkg::ST_READ && link_req.rd_byte && !link_req.reset_pulse
      |=> ta_q == $past(rp_q) && rp_q == ta_q + 16'h0001)
      else $error("target address not last byte read");
   busy_ones_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_q == smc_pkg::ST_SHA || st_q == smc_pkg::ST_ONES) && link_req.rd_bit
      |=> link_rsp.valid && link_rsp.data == 8'h01)
      else $error("busy slot not one");
   alt_pattern_a: assert property (@(posedge clk) disable iff (!rstn)
      st_q == smc_pkg::ST_ALT && link_req.rd_bit && !link_req.reset_pulse
      |=> link_rsp.data[0] != alt_q)
      else $error("completion pattern stuck");
   verify_gate_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(match_q) |-> host_flag_a_q && $past(st_q) == smc_pkg::ST_CRC)
      else $error("verified flag without host flag");
   bad_ctrl_a: assert property (@(posedge clk) disable iff (!rstn)
      sha_req.start |-> $past(st_q) == smc_pkg::ST_CRC &&
      ($past(cmd_q) == `SMC_CMD_READ_HOST_FLAG_A || $past(ok_q)))
      else $error("hash started on invalid request");
   host_flag_a_gate_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(host_flag_a_q) |-> $past(fn_q) == smc_pkg::FN_AUTHHOST && $past(sec_q) == $past(page[2:0]))
      else $error("host flag set with wrong secret");
   page_nibble_a: assert property (@(posedge clk) disable iff (!rstn)
      sha_req.start && sha_req.func == smc_pkg::FN_READ_HOST_FLAG_A |-> sha_req.msg_ctrl[3:0] == sha_req.page)
      else $error("page nibble wrong");
endmodule
`default_nettype wire

// ===== shared/smc_regs.svh
// Purpose: constants of the secure memory command unit
// Assumes: 100 MHz clock, byte-level link requests
// Notes:   definitions only
`ifndef SMC_REGS_SVH
`define SMC_REGS_SVH
// command codes
`define SMC_CMD_READ_MEM     8'hF0
`define SMC_CMD_ERASE_SP     8'hC3
`define SMC_CMD_MATCH_SP     8'h3C
`define SMC_CMD_READ_HOST_FLAG_A    8'hA5
`define SMC_CMD_COMPUTE      8'h33
// compute function control codes
`define SMC_FN_CODE_VALIDATE 8'h11
`define SMC_FN_CODE_SIGN     8'h12
`define SMC_FN_CODE_CHALL    8'h13
`define SMC_FN_CODE_AUTHHOST 8'h14
`define SMC_FN_CODE_FIRST    8'h15
`define SMC_FN_CODE_NEXT     8'h16
// memory map
`define SMC_PG_SECRET_A      5'h10
`define SMC_PG_SECRET_B      5'h11
`define SMC_PG_SCRATCH       5'h12
`define SMC_PG_PRNG          5'h15
`define SMC_PRNG_BYTES       5'h04
`define SMC_DATA_LIMIT       16'h0200
`define SMC_PAGE_CTR_BASE    10'h260
`define SMC_SEC_CTR_BASE     10'h280
`define SMC_MAC_FIRST        5'h08
`define SMC_MAC_LAST         5'h1B
`define SMC_MPX_BYTE         5'h0C
// timing
`define SMC_CLK_NS           32'd10
`define SMC_ERASE_NS         32'd32000
`define SMC_ERASE_CYC        (`SMC_ERASE_NS / `SMC_CLK_NS)
// register port
`define SMC_REG_STATUS       2'h0
`define SMC_REG_CTRL         2'h1
`define SMC_CTRL_RST         8'h00
`endif

// ===== shared/smc_pkg.sv
// Purpose: types of the secure memory command unit
// Assumes: nothing beyond the constants header
// Notes:   link signals and the engine request travel as packed structs
`default_nettype none
package smc_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR_LO, ST_ADDR_HI, ST_CTRL, ST_READ, ST_HOST_FLAG_A_RD, ST_MATCH,
      ST_CRC, ST_ERASE, ST_SHA, ST_ALT, ST_ONES
   } smc_state_t;
   typedef enum logic [2:0] {
      FN_NONE, FN_READ_HOST_FLAG_A, FN_VALIDATE, FN_SIGN, FN_CHALL, FN_AUTHHOST, FN_FIRST, FN_NEXT
   } smc_func_t;
   typedef struct packed {
      logic       reset_pulse;
      logic       wr_valid;
      logic [7:0] wr_byte;
      logic       rd_byte;
      logic       rd_bit;
   } smc_link_req_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } smc_link_rsp_t;
   typedef struct packed {
      logic       start;
      smc_func_t  func;
      logic [3:0] page;
      logic [7:0] msg_ctrl;
   } smc_sha_req_t;
endpackage
`default_nettype wire

// ===== test/smc_far_model.sv
// Purpose: memory and hash engine beside the command unit
// Assumes: memory reads are combinational from the address
// Notes:   hash latency is long enough that busy ones are always seen
`timescale 1ns/1ps
`default_nettype none
module smc_far_model (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rstn,
   // memory
   input  wire logic [9:0]            mem_raddr,
   output logic [7:0]                 mem_rdata,
   // hash engine
   input  wire smc_pkg::smc_sha_req_t sha_req,
   output logic                       sha_done,
   output logic [159:0]               sha_mac
);
   logic [7:0] cnt_q;
   assign mem_rdata = mem_raddr[7:0] ^ {6'h00, mem_raddr[9:8]} ^ 8'hA6;
   assign sha_mac = {20{8'hFF}};
   assign sha_done = cnt_q == 8'h01;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) cnt_q <= 8'h00;
      else if (sha_req.start) cnt_q <= 8'h28;
      else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
   end
endmodule
`default_nettype wire

// ===== test/smc_cmd_unit_bench.sv
// Purpose: self-checking bench of the command unit
// Assumes: answers come one cycle after each read request
// Notes:   expected bytes come from a bench model of the memory map
`timescale 1ns/1ps
`default_nettype none
`include "smc_regs.svh"
module smc_cmd_unit_bench;
   logic                   clk;
   logic                   rstn;
   smc_pkg::smc_link_req_t req;
   smc_pkg::smc_link_rsp_t rsp;
   smc_pkg::smc_sha_req_t  sha, last;
   logic [9:0]             mem_raddr;
   logic [7:0]             mem_rdata, reg_rdata, reg_wdata, got;
   logic [7:0]             q[$];
   logic [1:0]             reg_addr;
   logic                   reg_wr, reg_rd, sha_done, ok;
   logic [159:0]           sha_mac;
   logic [15:0]            crc, a, x;
   logic [31:0]            seed = 32'd48300;
   int                     bad_count, comparisons, starts, ones, n;
   logic [15:0]            rd_at [4] = '{16'h0100, 16'h01FC, 16'h025C, 16'h029E};
   logic [23:0]            jobs [11] = '{24'h130060, 24'h140060, 24'h130000, 24'h140100,
      24'h1200A0, 24'h120100, 24'h1101E0, 24'h150000, 24'h160120, 24'h770040, 24'h110200};
   smc_cmd_unit dut (.clk(clk), .rstn(rstn), .link_req(req), .link_rsp(rsp),
      .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .sha_req(sha), .sha_done(sha_done),
      .sha_mac(sha_mac), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   smc_far_model far (.clk(clk), .rstn(rstn), .mem_raddr(mem_raddr), .mem_rdata(mem_rdata),
      .sha_req(sha), .sha_done(sha_done), .sha_mac(sha_mac));
   function automatic logic [7:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
      c = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      return c;
   endfunction
   // hidden, undefined and out-of-map places all read as ones
   function automatic logic [7:0] exp_mem(input logic [15:0] x);
      if (x < 16'h0200 || (x >= 16'h0260 && x < 16'h02A4))
         return x[7:0] ^ {6'h00, x[9:8]} ^ 8'hA6;
      return 8'hFF;
   endfunction
   function automatic logic job_ok(input logic [7:0] c, input logic [3:0] p, input logic hi);
      if (hi) return 1'b0;
      case (c)
         `SMC_FN_CODE_SIGN: return p == 4'h0 || p == 4'h8;
         `SMC_FN_CODE_CHALL, `SMC_FN_CODE_AUTHHOST: return p != 4'h0 && p != 4'h8;
         `SMC_FN_CODE_VALIDATE, `SMC_FN_CODE_FIRST, `SMC_FN_CODE_NEXT: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction
   task automatic complete_run();
      if (bad_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] s);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, e, s);
      end
   endtask
   // kinds: 0 write byte, 1 read byte, 2 read bit, 3 reset pulse
   task automatic lk(input int k, input logic [7:0] b);
      smc_pkg::smc_link_req_t r;
      r = '0;
      r.wr_byte = b;
      r.wr_valid = k == 0;
      r.rd_byte = k == 1;
      r.rd_bit = k == 2;
      r.reset_pulse = k == 3;
      @(posedge clk);
      req <= r;
      @(posedge clk);
      req <= '0;
      #1 got = rsp.data;
      if (k == 1 || k == 2) chk("valid", 8'h01, {7'h00, rsp.valid});
   endtask
   task automatic regop(input logic w, input logic [1:0] ad, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= ad;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= !w;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1 got = reg_rdata;
   endtask
   task automatic send(input logic [7:0] bq[$]);
      lk(3, 8'h00);
      crc = 16'h0000;
      foreach (bq[i]) begin
         lk(0, bq[i]);
         crc = crc_upd(crc, bq[i]);
      end
   endtask
   task automatic crc_rd();
      lk(1, 8'h00);
      chk("crc_lo", ~crc[7:0], got);
      lk(1, 8'h00);
      chk("crc_hi", ~crc[15:8], got);
   endtask
   task automatic ones_chk(input int cnt);
      repeat (cnt) begin
         lk(2, 8'h00);
         chk("ones", 8'h01, got);
      end
   endtask
   // busy ones, then eight bits of the completion pattern
   task automatic done_pat(input int max);
      ones = 0;
      got = 8'h01;
      while (got === 8'h01 && ones < max) begin
         lk(2, 8'h00);
         ones += int'(got === 8'h01);
      end
      chk("done_bit", 8'h00, got);
      for (int i = 1; i < 8; i++) begin
         lk(2, 8'h00);
         chk("done_bit", 8'(i % 2), got);
      end
   endtask
   task automatic status(input logic [7:0] e);
      regop(1'b0, `SMC_REG_STATUS, 8'h00);
      chk("status", e, got);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      bad_count++;
      complete_run();
   end
   always @(negedge clk) if (sha.start) begin
      starts++;
      last = sha;
   end
   initial begin
      rstn = 1'b0;
      req = '0;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      status(8'h20);
      regop(1'b1, `SMC_REG_STATUS, 8'h00);
      regop(1'b0, 2'h3, 8'h00);
      chk("unmapped", 8'h00, got);
      status(8'h20);
      regop(1'b1, `SMC_REG_CTRL, 8'hFF);
      regop(1'b0, `SMC_REG_CTRL, 8'h00);
      chk("ctrl", 8'h01, got);
      rd_at[0] = {8'h01, rnd()};
      foreach (rd_at[i]) begin
         send({`SMC_CMD_READ_MEM, rd_at[i][7:0], rd_at[i][15:8]});
         for (int k = 0; k < 24; k++) begin
            lk(1, 8'h00);
            chk("mem", exp_mem(rd_at[i] + 16'(k)), got);
         end
      end
      send({`SMC_CMD_ERASE_SP, rnd(), 8'h00});
      done_pat(5000);
      // two cycles per read slot, a few slots of slack at each end
      chk("erase_busy", 8'h01, 8'(ones > `SMC_ERASE_CYC / 2 - 8 &&
         ones < `SMC_ERASE_CYC / 2 + 8));
      status(8'h00);
      q = {`SMC_CMD_MATCH_SP, rnd() & 8'h7F};
      repeat (19) q.push_back(rnd());
      send(q);
      crc_rd();
      ones_chk(16);
      foreach (jobs[i]) begin
         a = jobs[i][15:0];
         ok = job_ok(jobs[i][23:16], a[8:5], a[15:9] != 7'h00);
         n = starts;
         send({`SMC_CMD_COMPUTE, a[7:0], a[15:8], jobs[i][23:16]});
         crc_rd();
         repeat (3) @(negedge clk);
         chk("started", {7'h00, ok}, 8'(starts - n));
         if (ok) begin
            chk("page", {4'h0, a[8:5]}, {4'h0, last.page});
            // scratchpad byte 12 stays FFh from the erase and the all-ones macs
            chk("mp", jobs[i][23:16] == `SMC_FN_CODE_CHALL ? {4'h4, a[8:5]} : 8'h7F,
               last.msg_ctrl);
            done_pat(200);
         end else ones_chk(16);
      end
      // page 1 tail, then its page counter and its secret counter
      a = 16'h0038;
      send({`SMC_CMD_READ_HOST_FLAG_A, a[7:0], a[15:8]});
      for (int k = 0; k < 16; k++) begin
         x = k < 8 ? a + 16'(k) : k < 12 ? 16'h025C + 16'(k) : 16'h0278 + 16'(k);
         lk(1, 8'h00);
         chk("host_flag_a_rd", exp_mem(x), got);
         crc = crc_upd(crc, exp_mem(x));
      end
      crc_rd();
      done_pat(200);
      status(8'h33);
      q = {`SMC_CMD_MATCH_SP};
      repeat (20) q.push_back(8'hFF);
      send(q);
      crc_rd();
      done_pat(4);
      status(8'h3B);
      complete_run();
   end
endmodule
`default_nettype wire
